// ===== rtl/ccfb_core.sv
// Instruction unit for calls, returns, sleep, flag-register ops and block move.
// Overview of operation
// - Indirect call: SP-=2, push return PC, PC from word at aa:8; 8 states.
// - Return: PC from stack top, SP+=2; 8 states, flags untouched.
// - Exception return: pop flags, SP+=2, pop PC, SP+=2; 10 states.
// - Sleep enters the low-power state in 2 states, flags untouched.
// - Block move copies source byte to destination while count byte nonzero.
// - Each block-move step bumps both pointers and decrements the count.
// - Block move is 4 bytes long and takes 4n+9 states.
// - Primary opcode is taken from bits 15 to 8 of the first word.
// - Bit 7 of the first word selects between the two split groups.
// - Push and pop decode as word transfer with pre-decrement or post-increment.
`timescale 1ns/1ps
module ccfb_core
    import ccfb_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          resetn_i,
    input  wire logic [15:0]   mem_rdata_i,
    input  wire logic          wake_i,
    output ccfb_mem_req_t      mem_req_o,
    output logic [15:0]        pc_o,
    output logic [7:0]         ccr_o,
    output logic               sleep_o,
    output logic               retire_o
);

    ccfb_state_t   st_q;
    ccfb_mem_req_t req_q;
    logic [3:0]    cnt_q;
    logic [1:0]    lp_q;
    logic [15:0]   ir_q;
    logic [15:0]   tmp_q;
    logic [15:0]   pc_q;
    logic [7:0]    ccr_q;
    logic [15:0]   r_q [8];
    logic          retire_q;
    logic          sleep_q;
    logic [7:0]    op;
    logic [7:0]    fop;
    logic [3:0]    end_cnt;
    logic          looping;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [7:0] rd8(input logic [3:0] idx);
        rd8 = idx[3] ? r_q[idx[2:0]][7:0] : r_q[idx[2:0]][15:8];
    endfunction

    function automatic logic [15:0] wr8(input logic [15:0] w, input logic lo, input logic [7:0] b);
        wr8 = lo ? {w[15:8], b} : {b, w[7:0]};
    endfunction

    assign op  = ir_q[15:8];
    assign fop = mem_rdata_i[15:8];
    assign looping = (op == OP_BLOCK_MOVE) && (cnt_q == CNT_MOVE_LP) && (r_q[IDX_COUNT][7:0] != 8'h00);

    always_comb begin
        unique case (op)
            OP_CALL_INDIRECT: end_cnt = CNT_CALL_END;
            OP_RETURN:        end_cnt = CNT_RET_END;
            OP_EXC_RETURN:    end_cnt = CNT_RTE_END;
            OP_BLOCK_MOVE:    end_cnt = CNT_MOVE_END;
            default:          end_cnt = CNT_XFER_END;
        endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q     <= ST_FETCH0;
            cnt_q    <= 4'h0;
            lp_q     <= 2'h0;
            ir_q     <= 16'h0000;
            tmp_q    <= 16'h0000;
            pc_q     <= RST_PC;
            retire_q <= 1'b0;
            sleep_q  <= 1'b0;
        end else begin
            retire_q <= 1'b0;
            unique case (st_q)
                ST_FETCH0: st_q <= ST_FETCH1;
                ST_FETCH1: begin
                    ir_q  <= mem_rdata_i;
                    cnt_q <= 4'h0;
                    lp_q  <= 2'h0;
                    unique case (fop)
                        OP_SLEEP: begin
                            pc_q    <= pc_q + 16'h0002;
                            st_q    <= ST_SLEEP;
                            sleep_q <= 1'b1;
                        end
                        OP_CALL_INDIRECT, OP_RETURN, OP_EXC_RETURN, OP_WORD_TRANSFER, OP_BLOCK_MOVE: begin
                            st_q <= ST_EXEC;
                        end
                        default: begin
                            // Unsupported codes retire like a no-operation so the core never hangs.
                            pc_q     <= pc_q + 16'h0002;
                            retire_q <= 1'b1;
                            st_q     <= ST_FETCH0;
                        end
                    endcase
                end
                ST_EXEC: begin
                    if (looping) begin
                        lp_q <= lp_q + 2'h1;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if ((looping && lp_q == 2'h1) || (cnt_q == 4'h3 && op == OP_EXC_RETURN)
                            || (cnt_q == 4'h1 && (op == OP_CALL_INDIRECT || op == OP_RETURN))) begin
                        tmp_q <= mem_rdata_i;
                    end
                    if (!looping && cnt_q == end_cnt) begin
                        st_q     <= ST_FETCH0;
                        retire_q <= 1'b1;
                        unique case (op)
                            OP_CALL_INDIRECT, OP_RETURN, OP_EXC_RETURN: pc_q <= tmp_q;
                            OP_BLOCK_MOVE:    pc_q <= pc_q + 16'h0004;
                            default:          pc_q <= pc_q + 16'h0002;
                        endcase
                    end
                end
                ST_SLEEP: begin
                    if (wake_i) begin
                        st_q    <= ST_FETCH0;
                        sleep_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Memory requests
    // ****************************************
    // A request raised at one edge is seen by memory during the next state; data is taken at its end.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_q <= '0;
        end else begin
            req_q <= '0;
            if (st_q == ST_FETCH0) begin
                req_q.rd   <= 1'b1;
                req_q.addr <= pc_q;
            end else if (st_q == ST_EXEC) begin
                unique case (op)
                    OP_CALL_INDIRECT: begin
                        if (cnt_q == 4'h0) begin
                            req_q.rd   <= 1'b1;
                            req_q.addr <= {8'h00, ir_q[7:0]};
                        end else if (cnt_q == 4'h2) begin
                            req_q.wr    <= 1'b1;
                            req_q.addr  <= r_q[IDX_SP] - 16'h0002;
                            req_q.wdata <= pc_q + 16'h0002;
                        end
                    end
                    OP_RETURN, OP_EXC_RETURN: begin
                        if (cnt_q == 4'h0 || (cnt_q == 4'h2 && op == OP_EXC_RETURN)) begin
                            req_q.rd   <= 1'b1;
                            req_q.addr <= r_q[IDX_SP];
                        end
                    end
                    OP_WORD_TRANSFER: begin
                        if (cnt_q == 4'h0) begin
                            req_q.rd    <= !ir_q[7];
                            req_q.wr    <= ir_q[7];
                            req_q.addr  <= ir_q[7] ? r_q[ir_q[6:4]] - 16'h0002 : r_q[ir_q[6:4]];
                            req_q.wdata <= r_q[ir_q[2:0]];
                        end
                    end
                    OP_BLOCK_MOVE: begin
                        if (cnt_q == 4'h0) begin
                            req_q.rd   <= 1'b1;
                            req_q.addr <= pc_q + 16'h0002;
                        end else if (looping && lp_q == 2'h0) begin
                            req_q.rd       <= 1'b1;
                            req_q.byte_sel <= 1'b1;
                            req_q.addr     <= r_q[IDX_SRC];
                        end else if (looping && lp_q == 2'h2) begin
                            req_q.wr       <= 1'b1;
                            req_q.byte_sel <= 1'b1;
                            req_q.addr     <= r_q[IDX_DST];
                            req_q.wdata    <= {8'h00, tmp_q[7:0]};
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // General registers and flag register
    // ****************************************
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ccr_q <= RST_CCR;
            r_q   <= '{default: 16'h0000};
        end else if (st_q == ST_FETCH1) begin
            unique case (fop)
                OP_FLAGS_LOAD_IMM: ccr_q <= mem_rdata_i[7:0];
                OP_FLAGS_LOAD_REG: ccr_q <= rd8(mem_rdata_i[3:0]);
                OP_FLAGS_AND_IMM:  ccr_q <= ccr_q & mem_rdata_i[7:0];
                OP_FLAGS_OR_IMM:   ccr_q <= ccr_q | mem_rdata_i[7:0];
                OP_FLAGS_XOR_IMM:  ccr_q <= ccr_q ^ mem_rdata_i[7:0];
                OP_FLAGS_STORE: begin
                    r_q[mem_rdata_i[2:0]] <= wr8(r_q[mem_rdata_i[2:0]], mem_rdata_i[3], ccr_q);
                end
                default: ;
            endcase
        end else if (st_q == ST_EXEC) begin
            unique case (op)
                OP_CALL_INDIRECT: if (cnt_q == 4'h2) r_q[IDX_SP] <= r_q[IDX_SP] - 16'h0002;
                OP_RETURN:        if (cnt_q == 4'h1) r_q[IDX_SP] <= r_q[IDX_SP] + 16'h0002;
                OP_EXC_RETURN: begin
                    if (cnt_q == 4'h1) ccr_q <= mem_rdata_i[15:8];
                    if (cnt_q == 4'h1 || cnt_q == 4'h3) r_q[IDX_SP] <= r_q[IDX_SP] + 16'h0002;
                end
                OP_WORD_TRANSFER: begin
                    // The pointer update is written last, so a load into the pointer itself loses.
                    if (cnt_q == 4'h0 && ir_q[7]) begin
                        r_q[ir_q[6:4]] <= r_q[ir_q[6:4]] - 16'h0002;
                    end else if (cnt_q == 4'h1 && !ir_q[7]) begin
                        r_q[ir_q[2:0]] <= mem_rdata_i;
                        r_q[ir_q[6:4]] <= r_q[ir_q[6:4]] + 16'h0002;
                    end
                end
                OP_BLOCK_MOVE: begin
                    if (looping && lp_q == 2'h3) begin
                        r_q[IDX_SRC]   <= r_q[IDX_SRC] + 16'h0001;
                        r_q[IDX_DST]   <= r_q[IDX_DST] + 16'h0001;
                        r_q[IDX_COUNT] <= wr8(r_q[IDX_COUNT], 1'b1, r_q[IDX_COUNT][7:0] - 8'h01);
                    end
                end
                default: ;
            endcase
        end
    end

    assign mem_req_o = req_q;
    assign pc_o      = pc_q;
    assign ccr_o     = ccr_q;
    assign sleep_o   = sleep_q;
    assign retire_o  = retire_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [10:0] cyc_q;
    logic [15:0] sp0_q;
    logic [7:0]  ccr0_q;
    logic [7:0]  n_q;
    logic        chk;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cyc_q  <= 11'h000;
            sp0_q  <= 16'h0000;
            ccr0_q <= 8'h00;
            n_q    <= 8'h00;
        end else begin
            if (st_q == ST_FETCH0) begin
                cyc_q <= 11'h001;
            end else if (st_q != ST_SLEEP) begin
                cyc_q <= cyc_q + 11'h001;
            end
            if (st_q == ST_FETCH1) begin
                sp0_q  <= r_q[IDX_SP];
                ccr0_q <= ccr_q;
                n_q    <= r_q[IDX_COUNT][7:0];
            end
        end
    end

    assign chk = (st_q == ST_FETCH0) && (cyc_q != 11'h000);

    a_call_timing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_CALL_INDIRECT |-> cyc_q == T_CALL && r_q[IDX_SP] == sp0_q - 16'h0002 && ccr_q == ccr0_q)
        else $error("indirect call timing, stack or flags wrong");
    a_return_timing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_RETURN |-> cyc_q == T_RET && r_q[IDX_SP] == sp0_q + 16'h0002 && ccr_q == ccr0_q)
        else $error("return timing, stack or flags wrong");
    a_exc_return: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_EXC_RETURN |-> cyc_q == T_RTE && r_q[IDX_SP] == sp0_q + 16'h0004)
        else $error("exception return timing or stack wrong");
    a_sleep_entry: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        st_q == ST_FETCH1 && fop == OP_SLEEP |=> sleep_o && ccr_q == $past(ccr_q) ##1 (sleep_o || cyc_q == T_SHORT))
        else $error("sleep entry wrong");
    a_move_drains: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_BLOCK_MOVE |-> r_q[IDX_COUNT][7:0] == 8'h00)
        else $error("block move ended with nonzero count");
    a_move_step: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        st_q == ST_EXEC && looping && lp_q == 2'h3 |=> r_q[IDX_SRC] == $past(r_q[IDX_SRC]) + 16'h0001
            && r_q[IDX_DST] == $past(r_q[IDX_DST]) + 16'h0001)
        else $error("block move pointers not advanced");
    a_move_timing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_BLOCK_MOVE |-> cyc_q == {1'b0, n_q, 2'b00} + T_MOVE_BASE)
        else $error("block move state count wrong");
    a_push_decode: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        st_q == ST_EXEC && op == OP_WORD_TRANSFER && cnt_q == 4'h0 |=> (mem_req_o.wr == $past(ir_q[7]))
            && (mem_req_o.rd != $past(ir_q[7])))
        else $error("split-group selection wrong");
    a_flags_timing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op >= OP_FLAGS_STORE && op <= OP_FLAGS_LOAD_IMM |-> cyc_q == T_SHORT)
        else $error("flag instruction state count wrong");
    a_nop_hold: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        chk && op == OP_NO_OPERATION |-> cyc_q == T_SHORT && ccr_q == ccr0_q && pc_q == $past(pc_q, 2) + 16'h0002)
        else $error("no-operation changed state or timing");

endmodule

// ===== rtl/ccfb_pkg.sv
// Package for the control-flow, flag-register and block-move instruction unit.
package ccfb_pkg;

    // ****************************************
    // Primary operation codes
    // ****************************************
    localparam logic [7:0] OP_NO_OPERATION   = 8'h00;
    localparam logic [7:0] OP_SLEEP          = 8'h01;
    localparam logic [7:0] OP_FLAGS_STORE    = 8'h02;
    localparam logic [7:0] OP_FLAGS_LOAD_REG = 8'h03;
    localparam logic [7:0] OP_FLAGS_OR_IMM   = 8'h04;
    localparam logic [7:0] OP_FLAGS_XOR_IMM  = 8'h05;
    localparam logic [7:0] OP_FLAGS_AND_IMM  = 8'h06;
    localparam logic [7:0] OP_FLAGS_LOAD_IMM = 8'h07;
    localparam logic [7:0] OP_RETURN         = 8'h54;
    localparam logic [7:0] OP_EXC_RETURN     = 8'h56;
    localparam logic [7:0] OP_CALL_INDIRECT  = 8'h5f;
    localparam logic [7:0] OP_WORD_TRANSFER  = 8'h6d;
    localparam logic [7:0] OP_BLOCK_MOVE     = 8'h7b;

    // ****************************************
    // Reset values and register indices
    // ****************************************
    localparam logic [15:0] RST_PC    = 16'h0000;
    localparam logic [7:0]  RST_CCR   = 8'h80;
    localparam logic [2:0]  IDX_SP    = 3'h7;
    localparam logic [2:0]  IDX_COUNT = 3'h4;
    localparam logic [2:0]  IDX_SRC   = 3'h5;
    localparam logic [2:0]  IDX_DST   = 3'h6;

    // ****************************************
    // Execute-step positions and state totals
    // ****************************************
    localparam logic [3:0]  CNT_CALL_END = 4'h5;
    localparam logic [3:0]  CNT_RET_END  = 4'h5;
    localparam logic [3:0]  CNT_RTE_END  = 4'h7;
    localparam logic [3:0]  CNT_XFER_END = 4'h3;
    localparam logic [3:0]  CNT_MOVE_END = 4'h6;
    localparam logic [3:0]  CNT_MOVE_LP  = 4'h2;
    localparam logic [10:0] T_CALL       = 11'h008;
    localparam logic [10:0] T_RET        = 11'h008;
    localparam logic [10:0] T_RTE        = 11'h00a;
    localparam logic [10:0] T_SHORT      = 11'h002;
    localparam logic [10:0] T_MOVE_BASE  = 11'h009;

    typedef enum logic [1:0] {
        ST_FETCH0 = 2'b00,
        ST_FETCH1 = 2'b01,
        ST_EXEC   = 2'b10,
        ST_SLEEP  = 2'b11
    } ccfb_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        byte_sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ccfb_mem_req_t;

endpackage

// ===== verif/ccfb_mem_model.sv
// Zero-wait on-chip memory model that answers the instruction unit's bus.
`timescale 1ns/1ps
module ccfb_mem_model
    import ccfb_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire ccfb_mem_req_t mem_req_i,
    output logic [15:0]        mem_rdata_o
);
    // ****************************************
    // Storage and read path
    // ****************************************
    logic [7:0]  mem [0:65535];
    logic [15:0] last_q;

    initial begin
        last_q = 16'h0000;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end

    // Outside a read the lines show the inverse of the last answer, so a late sample cannot match by chance.
    always_comb begin
        if (mem_req_i.rd && mem_req_i.byte_sel) begin
            mem_rdata_o = {8'h00, mem[mem_req_i.addr]};
        end else if (mem_req_i.rd) begin
            mem_rdata_o = {mem[mem_req_i.addr], mem[mem_req_i.addr + 16'h0001]};
        end else begin
            mem_rdata_o = ~last_q;
        end
    end

    always @(posedge core_clk_i) begin
        if (mem_req_i.rd) begin
            last_q <= mem_rdata_o;
        end
        if (mem_req_i.wr && mem_req_i.byte_sel) begin
            mem[mem_req_i.addr] <= mem_req_i.wdata[7:0];
        end else if (mem_req_i.wr) begin
            mem[mem_req_i.addr]            <= mem_req_i.wdata[15:8];
            mem[mem_req_i.addr + 16'h0001] <= mem_req_i.wdata[7:0];
        end
    end
endmodule

// ===== verif/ccfb_core_bench.sv
// Self-checking bench for the call, return, sleep, flag and block-move unit.
`timescale 1ns/1ps
module ccfb_core_bench
    import ccfb_pkg::*;
;
    // ****************************************
    // Design, memory and clock
    // ****************************************
    logic          core_clk_i;
    logic          resetn_i;
    logic          wake_i;
    logic [15:0]   mem_rdata;
    ccfb_mem_req_t mem_req;
    logic [15:0]   pc;
    logic [7:0]    condition_code_register;
    logic          sleep;
    logic          retire;
    int            fails;
    int            samples_checked;
    logic [15:0]   pa;
    logic [15:0]   epc;

    ccfb_core i_ccfb_core (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .mem_rdata_i(mem_rdata),
        .wake_i(wake_i), .mem_req_o(mem_req), .pc_o(pc), .ccr_o(condition_code_register), .sleep_o(sleep), .retire_o(retire));
    ccfb_mem_model i_ccfb_mem_model (.core_clk_i(core_clk_i), .mem_req_i(mem_req), .mem_rdata_o(mem_rdata));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d checked, %0d mismatches", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic w16(input logic [15:0] a, input logic [15:0] v);
        i_ccfb_mem_model.mem[a] = v[15:8];
        i_ccfb_mem_model.mem[a + 16'h0001] = v[7:0];
    endtask

    function automatic logic [15:0] r16(input logic [15:0] a);
        return {i_ccfb_mem_model.mem[a], i_ccfb_mem_model.mem[a + 16'h0001]};
    endfunction

    task automatic ins(input logic [15:0] v);
        w16(pa, v);
        pa = pa + 16'h0002;
    endtask

    // Registers are set here through the flag register, so each byte costs a load and a store.
    task automatic setb(input logic [3:0] idx, input logic [7:0] v);
        ins({OP_FLAGS_LOAD_IMM, v});
        ins({OP_FLAGS_STORE, 4'h0, idx});
    endtask

    task automatic setw(input logic [2:0] r, input logic [15:0] v);
        setb({1'b0, r}, v[15:8]);
        setb({1'b1, r}, v[7:0]);
    endtask

    task automatic adv(input int st, input logic [15:0] npc);
        int n;
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
            if (n > 2000) begin
                fails++;
                $display("[ERR] retire expected pulse seen none");
                tally_and_finish();
            end
        end while (retire !== 1'b1);
        if (st > 0) check("states", n[15:0], st[15:0]);
        check("pc", pc, npc);
        epc = npc;
    endtask

    task automatic shorts(input int k);
        repeat (k) adv(2, epc + 16'h0002);
    endtask

    // Every program starts with a no-operation at address zero so state counts start from a retire.
    task automatic start();
        @(negedge core_clk_i);
        resetn_i = 1'b0;
        wake_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        check("pc", pc, RST_PC);
        check("ccr", {8'h00, condition_code_register}, {8'h00, RST_CCR});
        check("idle", {12'h000, sleep, retire, mem_req.rd, mem_req.wr}, 16'h0000);
        resetn_i = 1'b1;
        adv(0, 16'h0002);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_nop();
        pa = 16'h0000;
        repeat (3) ins({OP_NO_OPERATION, 8'h00});
        start();
        adv(2, 16'h0004);
        adv(2, 16'h0006);
        check("ccr", {8'h00, condition_code_register}, {8'h00, RST_CCR});
        $display("Test no_operation done");
    endtask

    task automatic s_flags();
        logic [7:0] op [3] = '{OP_FLAGS_OR_IMM, OP_FLAGS_XOR_IMM, OP_FLAGS_AND_IMM};
        logic [7:0] im [3] = '{8'h81, 8'hff, 8'h0f};
        logic [7:0] ex [3] = '{8'hdb, 8'h24, 8'h04};
        pa = 16'h0000;
        ins({OP_NO_OPERATION, 8'h00});
        setw(3'h7, 16'h0400);
        setb(4'h9, 8'h5a);
        for (int i = 0; i < 3; i++) ins({op[i], im[i]});
        ins({OP_FLAGS_LOAD_REG, 8'h09});
        ins({OP_WORD_TRANSFER, 8'h73});
        ins({OP_WORD_TRANSFER, 8'hf3});
        ins({OP_WORD_TRANSFER, 8'hf3});
        ins({OP_WORD_TRANSFER, 8'hf1});
        w16(16'h0400, 16'ha5c3);
        start();
        shorts(5);
        check("ccr", {8'h00, condition_code_register}, 16'h005a);
        shorts(1);
        for (int i = 0; i < 3; i++) begin
            adv(2, epc + 16'h0002);
            check("ccr", {8'h00, condition_code_register}, {8'h00, ex[i]});
        end
        ins({OP_NO_OPERATION, 8'h00});
        check("ccr", {8'h00, condition_code_register}, 16'h0004);
        adv(2, epc + 16'h0002);
        check("ccr", {8'h00, condition_code_register}, 16'h005a);
        repeat (4) adv(6, epc + 16'h0002);
        check("stack", r16(16'h03fe), 16'ha5c3);
        check("stack", r16(16'h03fc), 16'h005a);
        $display("Test flag_ops done");
    endtask

    task automatic s_call();
        pa = 16'h0000;
        ins({OP_NO_OPERATION, 8'h00});
        setw(3'h7, 16'h0400);
        ins({OP_FLAGS_LOAD_IMM, 8'hc5});
        ins({OP_CALL_INDIRECT, 8'h40});
        ins({OP_EXC_RETURN, 8'h00});
        w16(16'h0040, 16'h0200);
        w16(16'h0200, {OP_RETURN, 8'h00});
        w16(16'h0300, {OP_WORD_TRANSFER, 8'hf0});
        w16(16'h0400, 16'h2b00);
        w16(16'h0402, 16'h0300);
        start();
        shorts(5);
        adv(8, 16'h0200);
        check("ret", r16(16'h03fe), 16'h000e);
        check("ccr", {8'h00, condition_code_register}, 16'h00c5);
        adv(8, 16'h000e);
        check("ccr", {8'h00, condition_code_register}, 16'h00c5);
        adv(10, 16'h0300);
        check("ccr", {8'h00, condition_code_register}, 16'h002b);
        adv(6, 16'h0302);
        check("stack", r16(16'h0402), 16'h0000);
        $display("Test call_return done");
    endtask

    task automatic s_move();
        pa = 16'h0000;
        ins({OP_NO_OPERATION, 8'h00});
        setw(3'h7, 16'h0400);
        setw(3'h5, 16'h0500);
        setw(3'h6, 16'h0600);
        setb(4'hc, 8'h03);
        for (int k = 0; k < 2; k++) begin
            ins({OP_BLOCK_MOVE, 8'h5c});
            ins(16'h598f);
            if (k == 0) for (int r = 5; r >= 4; r--) ins({OP_WORD_TRANSFER, 5'h1e, r[2:0] + 3'h1});
            if (k == 0) ins({OP_WORD_TRANSFER, 8'hf4});
        end
        w16(16'h0500, 16'h1122);
        w16(16'h0502, 16'h3344);
        w16(16'h0600, 16'heeee);
        w16(16'h0602, 16'heeee);
        start();
        shorts(14);
        adv(4 * 3 + 9, epc + 16'h0004);
        check("dst", r16(16'h0600), 16'h1122);
        check("dst", r16(16'h0602), 16'h33ee);
        repeat (3) adv(6, epc + 16'h0002);
        check("dst", r16(16'h03fe), 16'h0603);
        check("src", r16(16'h03fc), 16'h0503);
        check("count", r16(16'h03fa), 16'h0000);
        adv(9, epc + 16'h0004);
        check("dst", r16(16'h0602), 16'h33ee);
        $display("Test block_move done");
    endtask

    task automatic s_sleep();
        int n;
        pa = 16'h0000;
        ins({OP_NO_OPERATION, 8'h00});
        ins({OP_FLAGS_LOAD_IMM, 8'h17});
        ins({OP_SLEEP, 8'h00});
        ins({OP_NO_OPERATION, 8'h00});
        start();
        adv(2, 16'h0004);
        n = 0;
        do begin
            @(negedge core_clk_i);
            n++;
            if (n > 50) begin
                fails++;
                $display("[ERR] sleep expected high seen low");
                tally_and_finish();
            end
        end while (sleep !== 1'b1);
        check("sleep_states", n[15:0], 16'h0002);
        repeat (6) @(negedge core_clk_i);
        check("asleep", {14'h0000, sleep, retire}, 16'h0002);
        check("pc", pc, 16'h0006);
        check("ccr", {8'h00, condition_code_register}, 16'h0017);
        wake_i = 1'b1;
        @(negedge core_clk_i);
        wake_i = 1'b0;
        adv(0, 16'h0008);
        $display("Test sleep_wake done");
    endtask

    initial begin
        resetn_i = 1'b0;
        wake_i = 1'b0;
        fails = 0;
        samples_checked = 0;
        pa = 16'h0000;
        epc = 16'h0000;
        s_nop();
        s_flags();
        s_call();
        s_move();
        s_sleep();
        tally_and_finish();
    end
endmodule
